// ### rtl/sram_core_pkg.sv
package sram_core_pkg;

	localparam int ADDR_W = 19;
	localparam int BYTE_LANES = 4;
	localparam int BYTE_W = 8;
	localparam int DATA_W = BYTE_LANES * BYTE_W;
	localparam int WORD_W = DATA_W + BYTE_LANES;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BURST_W = 2;

	localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic BURST_LINEAR = 1'b0;
	localparam logic BURST_INTERLEAVED = 1'b1;

	// sleep entry and exit, in clock cycles
	localparam logic [1:0] SLEEP_ENTER_CYCLES = 2'h2;
	localparam logic [1:0] SLEEP_EXIT_CYCLES = 2'h2;
	localparam logic [1:0] SLEEP_COUNT_START = 2'h1;

	typedef enum logic [1:0] {
		SLEEP_AWAKE,
		SLEEP_ENTERING,
		SLEEP_ASLEEP,
		SLEEP_LEAVING
	} sleep_state_e;

	typedef struct packed {
		logic [BYTE_LANES-1:0] parity;
		logic [DATA_W-1:0] data;
	} word_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_LANES-1:0] lane_sel_n;
	} access_s;

	localparam access_s ACCESS_IDLE = '{valid: 1'b0, write: 1'b0, addr: '0, lane_sel_n: '1};

	// next low address bits of a burst
	function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] count, input logic order);
		if (order == BURST_INTERLEAVED)
			burst_low = start ^ count;
		else
			burst_low = start + count;
	endfunction

	// replace only the selected byte lanes (data byte with its parity bit)
	function automatic word_s merge_lanes(input word_s old_word, input word_s new_word,
		input logic [BYTE_LANES-1:0] sel_n);
		merge_lanes = old_word;
		for (int i = 0; i < BYTE_LANES; i++)
		begin
			if (!sel_n[i])
			begin
				merge_lanes.data[i*BYTE_W +: BYTE_W] = new_word.data[i*BYTE_W +: BYTE_W];
				merge_lanes.parity[i] = new_word.parity[i];
			end
		end
	endfunction

endpackage

// ### rtl/sram_word_array.sv
`timescale 1ns/1ns
`default_nettype none
module sram_word_array (
	input wire logic clk_in,
	input wire logic write_in,
	input wire logic [sram_core_pkg::ADDR_W-1:0] write_addr_in,
	input wire logic [sram_core_pkg::BYTE_LANES-1:0] lane_sel_n_in,
	input wire sram_core_pkg::word_s write_word_in,
	input wire logic [sram_core_pkg::ADDR_W-1:0] read_addr_in,
	output sram_core_pkg::word_s read_word_out
);

	// contents have no reset: they survive sleep and controller resets
	sram_core_pkg::word_s mem [0:sram_core_pkg::DEPTH-1];

	always_ff @(posedge clk_in)
	begin
		if (write_in)
			mem[write_addr_in] <= sram_core_pkg::merge_lanes(mem[write_addr_in],
				write_word_in, lane_sel_n_in);
	end

	assign read_word_out = mem[read_addr_in];

endmodule // sram_word_array
`default_nettype wire

// ### rtl/pipelined_burst_sram_core.sv
`timescale 1ns/1ns
`default_nettype none
module pipelined_burst_sram_core (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CLOCK_GATE_N_IN,
	input wire logic CHIP_SELECT_1_N_IN,
	input wire logic CHIP_SELECT_2_IN,
	input wire logic CHIP_SELECT_3_N_IN,
	input wire logic ADVANCE_OR_LOAD_IN,
	input wire logic WRITE_N_IN,
	input wire logic [sram_core_pkg::BYTE_LANES-1:0] BYTE_LANE_SELECT_N_IN,
	input wire logic [sram_core_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic OUTPUT_ENABLE_N_IN,
	input wire logic BURST_ORDER_IN,
	input wire logic SLEEP_REQUEST_IN,
	input wire logic [sram_core_pkg::DATA_W-1:0] DATA_IN,
	output logic [sram_core_pkg::DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_OUT,
	input wire logic [sram_core_pkg::BYTE_LANES-1:0] PARITY_LINES_IN,
	output logic [sram_core_pkg::BYTE_LANES-1:0] PARITY_LINES_OUT,
	output logic PARITY_LINES_OE_OUT,
	output logic ASLEEP_OUT
);

	logic qualified;
	logic awake;
	logic run;
	logic selected;
	logic load;

	sram_core_pkg::sleep_state_e sleep_q;
	sram_core_pkg::sleep_state_e sleep_d;
	logic [1:0] sleep_cnt_q;
	logic [1:0] sleep_cnt_d;

	logic strap_taken_q;
	logic burst_order_q;

	logic burst_active_q;
	logic burst_write_q;
	logic [sram_core_pkg::ADDR_W-1:0] burst_base_q;
	logic [sram_core_pkg::BURST_W-1:0] burst_start_q;
	logic [sram_core_pkg::BURST_W-1:0] burst_count_q;
	logic [sram_core_pkg::BURST_W-1:0] burst_count_d;

	sram_core_pkg::access_s issue;
	sram_core_pkg::access_s stage1_q;
	sram_core_pkg::access_s stage2_q;

	sram_core_pkg::word_s write_word;
	sram_core_pkg::word_s array_word;
	sram_core_pkg::word_s read_word;
	logic array_write;

	logic drive_q;
	logic [sram_core_pkg::DATA_W-1:0] data_q;
	logic [sram_core_pkg::BYTE_LANES-1:0] parity_q;
	logic asleep_q;
	logic out_enable;

	// slot decodes shared by the array write and the output stage
	function automatic logic is_read(input sram_core_pkg::access_s slot);
		is_read = slot.valid && !slot.write;
	endfunction

	function automatic logic is_write(input sram_core_pkg::access_s slot);
		is_write = slot.valid && slot.write;
	endfunction

	assign qualified = !CLOCK_GATE_N_IN;
	assign awake = (sleep_q == sram_core_pkg::SLEEP_AWAKE);
	assign run = qualified && awake;
	assign selected = !CHIP_SELECT_1_N_IN && CHIP_SELECT_2_IN && !CHIP_SELECT_3_N_IN;
	assign load = !ADVANCE_OR_LOAD_IN;

	// a request that drops part way into entry turns straight into an exit,
	// so the two recovery cycles always run before commands are taken again
	// low request stays awake
	always_comb
	begin
		sleep_d = sleep_q;
		sleep_cnt_d = sleep_cnt_q;
		case (sleep_q)
			sram_core_pkg::SLEEP_AWAKE:
			begin
				if (SLEEP_REQUEST_IN)
				begin
					sleep_d = sram_core_pkg::SLEEP_ENTERING;
					sleep_cnt_d = sram_core_pkg::SLEEP_COUNT_START;
				end
			end
			sram_core_pkg::SLEEP_ENTERING:
			begin
				if (!SLEEP_REQUEST_IN)
				begin
					sleep_d = sram_core_pkg::SLEEP_LEAVING;
					sleep_cnt_d = sram_core_pkg::SLEEP_COUNT_START;
				end
				else if (sleep_cnt_q == sram_core_pkg::SLEEP_ENTER_CYCLES - 2'h1)
					sleep_d = sram_core_pkg::SLEEP_ASLEEP;
				else
					sleep_cnt_d = sleep_cnt_q + 2'h1;
			end
			sram_core_pkg::SLEEP_ASLEEP:
			begin
				if (!SLEEP_REQUEST_IN)
				begin
					sleep_d = sram_core_pkg::SLEEP_LEAVING;
					sleep_cnt_d = sram_core_pkg::SLEEP_COUNT_START;
				end
			end
			sram_core_pkg::SLEEP_LEAVING:
			begin
				if (SLEEP_REQUEST_IN)
				begin
					sleep_d = sram_core_pkg::SLEEP_ENTERING;
					sleep_cnt_d = sram_core_pkg::SLEEP_COUNT_START;
				end
				else if (sleep_cnt_q == sram_core_pkg::SLEEP_EXIT_CYCLES - 2'h1)
					sleep_d = sram_core_pkg::SLEEP_AWAKE;
				else
					sleep_cnt_d = sleep_cnt_q + 2'h1;
			end
			default:
			begin
				sleep_d = sram_core_pkg::SLEEP_AWAKE;
				sleep_cnt_d = '0;
			end
		endcase
	end

	// sleep runs on every edge: the clock gate does not hold it off
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			sleep_q <= sram_core_pkg::SLEEP_AWAKE;
			sleep_cnt_q <= '0;
			asleep_q <= 1'b0;
		end
		else
		begin
			sleep_q <= sleep_d;
			sleep_cnt_q <= sleep_cnt_d;
			asleep_q <= (sleep_d == sram_core_pkg::SLEEP_ASLEEP);
		end
	end

	// the strap is meant to stay put; a later change waits for the next reset
	// strap caught once
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			strap_taken_q <= 1'b0;
			burst_order_q <= sram_core_pkg::BURST_LINEAR;
		end
		else if (!strap_taken_q)
		begin
			strap_taken_q <= 1'b1;
			burst_order_q <= BURST_ORDER_IN;
		end
	end

	// the first edge after reset has no strap yet: use the pin directly
	logic order;
	assign order = strap_taken_q ? burst_order_q : BURST_ORDER_IN;

	assign burst_count_d = burst_count_q + sram_core_pkg::BURST_STEP;

	always_comb
	begin
		issue = sram_core_pkg::ACCESS_IDLE;
		if (load)
		begin
			issue.valid = selected;
			issue.write = !WRITE_N_IN;
			issue.addr = ADDR_IN;
		end
		else
		begin
			issue.valid = burst_active_q;
			issue.write = burst_write_q;
			issue.addr = {burst_base_q[sram_core_pkg::ADDR_W-1:sram_core_pkg::BURST_W],
				sram_core_pkg::burst_low(burst_start_q, burst_count_d, order)};
		end
		// selects travel with each beat, not with its data two edges later
		// selects sampled per beat
		issue.lane_sel_n = BYTE_LANE_SELECT_N_IN;
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			burst_active_q <= 1'b0;
			burst_write_q <= 1'b0;
			burst_base_q <= '0;
			burst_start_q <= sram_core_pkg::BURST_FIRST;
			burst_count_q <= sram_core_pkg::BURST_FIRST;
		end
		else if (!awake)
			burst_active_q <= 1'b0;
		else if (run)
		begin
			if (load)
			begin
				burst_active_q <= selected;
				burst_write_q <= !WRITE_N_IN;
				burst_base_q <= ADDR_IN;
				burst_start_q <= ADDR_IN[sram_core_pkg::BURST_W-1:0];
				burst_count_q <= sram_core_pkg::BURST_FIRST;
			end
			else
				burst_count_q <= burst_count_d;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			stage1_q <= sram_core_pkg::ACCESS_IDLE;
			stage2_q <= sram_core_pkg::ACCESS_IDLE;
		end
		else if (!awake)
		begin
			// flushed even under a stall: a half-done write must not land later
			// pending accesses dropped
			stage1_q <= sram_core_pkg::ACCESS_IDLE;
			stage2_q <= sram_core_pkg::ACCESS_IDLE;
		end
		else if (run)
		begin
			stage1_q <= issue;
			stage2_q <= stage1_q;
		end
	end

	assign write_word = '{parity: PARITY_LINES_IN, data: DATA_IN};

	assign array_write = run && is_write(stage2_q);

	sram_word_array u_array (
		.clk_in(CLK_IN),
		.write_in(array_write),
		.write_addr_in(stage2_q.addr),
		.lane_sel_n_in(stage2_q.lane_sel_n),
		.write_word_in(write_word),
		.read_addr_in(stage1_q.addr),
		.read_word_out(array_word)
	);

	// a write completing on this edge must be seen by a read issued just after it
	always_comb
	begin
		read_word = array_word;
		if (array_write && (stage2_q.addr == stage1_q.addr))
			read_word = sram_core_pkg::merge_lanes(array_word, write_word,
				stage2_q.lane_sel_n);
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			drive_q <= 1'b0;
			data_q <= '0;
			parity_q <= '0;
		end
		else if (!awake)
			drive_q <= 1'b0;
		else if (run)
		begin
			drive_q <= is_read(stage1_q);
			if (is_read(stage1_q))
			begin
				data_q <= read_word.data;
				parity_q <= read_word.parity;
			end
		end
	end

	assign DATA_OUT = data_q;
	assign PARITY_LINES_OUT = parity_q;
	assign ASLEEP_OUT = asleep_q;

	// the enable pin is asynchronous, so it gates the registered drive without a clock
	// enable masks drive
	assign out_enable = drive_q && !OUTPUT_ENABLE_N_IN;
	assign DATA_OE_OUT = out_enable;
	assign PARITY_LINES_OE_OUT = out_enable;

endmodule // pipelined_burst_sram_core
`default_nettype wire

// ### verification/sram_core_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sram_core_monitor (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CLOCK_GATE_N_IN,
	input wire logic CHIP_SELECT_1_N_IN,
	input wire logic CHIP_SELECT_2_IN,
	input wire logic CHIP_SELECT_3_N_IN,
	input wire logic ADVANCE_OR_LOAD_IN,
	input wire logic WRITE_N_IN,
	input wire logic OUTPUT_ENABLE_N_IN,
	input wire logic SLEEP_REQUEST_IN,
	input wire logic [sram_core_pkg::DATA_W-1:0] DATA_OUT,
	input wire logic DATA_OE_OUT,
	input wire logic ASLEEP_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	logic [1:0] awake_q;
	wire logic sel = !CHIP_SELECT_1_N_IN && CHIP_SELECT_2_IN && !CHIP_SELECT_3_N_IN;
	wire logic go = awake_q == 2'h3 && !SLEEP_REQUEST_IN && !CLOCK_GATE_N_IN && !ADVANCE_OR_LOAD_IN;
	wire logic nxt = !CLOCK_GATE_N_IN && !SLEEP_REQUEST_IN;
	// conservative: three quiet edges before commands count
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
		if (!RESET_N_IN)
			awake_q <= 2'h0;
		else if (SLEEP_REQUEST_IN || ASLEEP_OUT)
			awake_q <= 2'h0;
		else if (awake_q != 2'h3)
			awake_q <= awake_q + 2'h1;
	property p_gate;
		CLOCK_GATE_N_IN |=> $stable(DATA_OUT);
	endproperty
	a_gate: assert property (p_gate) else $error("stalled edge moved read data");
	property p_read;
		go && sel && WRITE_N_IN ##1 nxt |=> DATA_OE_OUT || OUTPUT_ENABLE_N_IN;
	endproperty
	a_read: assert property (p_read) else $error("read not driven");
	property p_oe;
		OUTPUT_ENABLE_N_IN |-> !DATA_OE_OUT;
	endproperty
	a_oe: assert property (p_oe) else $error("driving with enable high");
	property p_desel;
		go && !sel ##1 nxt |=> !DATA_OE_OUT;
	endproperty
	a_desel: assert property (p_desel) else $error("deselect left data driven");
	property p_write;
		go && sel && !WRITE_N_IN ##1 nxt |=> !DATA_OE_OUT;
	endproperty
	a_write: assert property (p_write) else $error("driving during write data");
	property p_enter;
		awake_q == 2'h3 && !SLEEP_REQUEST_IN ##1 SLEEP_REQUEST_IN [*2] |-> !ASLEEP_OUT ##1 ASLEEP_OUT;
	endproperty
	a_enter: assert property (p_enter) else $error("sleep entry not two cycles");
	property p_stay;
		ASLEEP_OUT && SLEEP_REQUEST_IN |=> ASLEEP_OUT;
	endproperty
	a_stay: assert property (p_stay) else $error("left sleep early");
	property p_wake;
		ASLEEP_OUT && !SLEEP_REQUEST_IN |=> !ASLEEP_OUT;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep exit not started");
	property p_flush;
		SLEEP_REQUEST_IN && !CLOCK_GATE_N_IN |=> !DATA_OE_OUT;
	endproperty
	a_flush: assert property (p_flush) else $error("access kept at sleep entry");
	property p_reset;
		$rose(RESET_N_IN) |-> !DATA_OE_OUT && !ASLEEP_OUT;
	endproperty
	a_reset: assert property (p_reset) else $error("not idle after reset");
endmodule // sram_core_monitor
`default_nettype wire

// ### verification/sram_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module sram_ctrl_model (
	input wire logic clk_in,
	input wire logic gate_n_in,
	input wire logic beat_in,
	input wire sram_core_pkg::word_s word_in,
	output sram_core_pkg::word_s word_out
);
	logic pend_q = 1'b0;
	logic drive_q = 1'b0;
	sram_core_pkg::word_s next_q = '0;
	sram_core_pkg::word_s hold_q = '0;
	always @(posedge clk_in)
	begin
		if (!gate_n_in)
		begin
			pend_q <= beat_in;
			next_q <= word_in;
			drive_q <= pend_q;
			if (pend_q)
				hold_q <= next_q;
		end
	end
	assign word_out = drive_q ? hold_q : ~hold_q;
endmodule // sram_ctrl_model
`default_nettype wire

// ### verification/pipelined_burst_sram_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("wrong value at %0t: got %h expected %h", $time, g, e); \
		end \
	end
module pipelined_burst_sram_core_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic gate_n = 1'b0;
	logic cs_n = 1'b1;
	logic cs2_off = 1'b0;
	logic adv = 1'b0;
	logic wn = 1'b1;
	logic oe_n = 1'b0;
	logic order = 1'b0;
	logic zz = 1'b0;
	logic beat = 1'b0;
	logic [3:0] lanes_n = 4'hf;
	logic [18:0] addr = 19'h0;
	sram_core_pkg::word_s wword = '0;
	sram_core_pkg::word_s bus;
	logic [31:0] rdat;
	logic [3:0] rpar;
	logic oe;
	logic poe;
	logic asleep;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	pipelined_burst_sram_core DUT (
		.CLK_IN(clk), .RESET_N_IN(rst_n), .CLOCK_GATE_N_IN(gate_n),
		.CHIP_SELECT_1_N_IN(cs_n), .CHIP_SELECT_2_IN(!cs_n && !cs2_off),
		.CHIP_SELECT_3_N_IN(cs_n),
		.ADVANCE_OR_LOAD_IN(adv), .WRITE_N_IN(wn), .BYTE_LANE_SELECT_N_IN(lanes_n),
		.ADDR_IN(addr), .OUTPUT_ENABLE_N_IN(oe_n), .BURST_ORDER_IN(order),
		.SLEEP_REQUEST_IN(zz), .DATA_IN(bus.data), .DATA_OUT(rdat), .DATA_OE_OUT(oe),
		.PARITY_LINES_IN(bus.parity), .PARITY_LINES_OUT(rpar), .PARITY_LINES_OE_OUT(poe),
		.ASLEEP_OUT(asleep));
	sram_ctrl_model CTRL (.clk_in(clk), .gate_n_in(gate_n), .beat_in(beat),
		.word_in(wword), .word_out(bus));
	task automatic report_and_stop;
		$display("compared %0d, wrong %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			report_and_stop;
		end
	end
	// lane selects and data given afresh on every beat
	task automatic cmd(input logic l, input logic s, input logic w, input logic b,
		input logic [18:0] a, input logic [3:0] ln, input sram_core_pkg::word_s d);
		adv = !l;
		cs_n = !s;
		wn = !w;
		beat = b;
		addr = a;
		lanes_n = ln;
		wword = d;
		@(posedge clk);
		#1;
	endtask
	task automatic idle(input int n);
		repeat (n) cmd(1, 0, 0, 0, '0, 4'hf, '0);
	endtask
	task automatic rd_chk(input logic [18:0] a, input logic [35:0] e);
		cmd(1, 1, 0, 0, a, 4'hf, '0);
		idle(1);
		`CHK({rpar, rdat}, e)
	endtask
	task automatic do_reset(input logic o);
		rst_n = 1'b0;
		order = o;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		`CHK(oe, 1'b0)
	endtask
	task automatic t_write_read;
		cmd(1, 1, 1, 1, 19'h100, 4'h0, 36'h9_deadbeef);
		cmd(1, 1, 0, 0, 19'h100, 4'hf, '0);
		`CHK(oe, 1'b0)
		`CHK(poe, 1'b0)
		idle(1);
		`CHK({rpar, rdat}, 36'h9_deadbeef)
		`CHK(oe, 1'b1)
		idle(1);
		`CHK(oe, 1'b0)
		cs2_off = 1'b1;
		cmd(1, 1, 0, 0, 19'h100, 4'hf, '0);
		cs2_off = 1'b0;
		idle(1);
		`CHK(oe, 1'b0)
	endtask
	task automatic t_lanes;
		cmd(1, 1, 1, 1, 19'h200, 4'h0, 36'h0_11111111);
		cmd(1, 1, 1, 1, 19'h200, 4'ha, 36'hf_22222222);
		idle(3);
		rd_chk(19'h200, 36'h5_11221122);
	endtask
	task automatic t_burst;
		cmd(1, 1, 1, 1, 19'h301, 4'h0, 36'ha0);
		for (int k = 1; k < 4; k++)
			cmd(0, 0, 0, 1, 19'h7ffff, 4'h0, 36'ha0 + k);
		idle(2);
		for (int k = 0; k < 4; k++)
			rd_chk(19'h300 + 19'((1 + k) % 4), 36'ha0 + k);
		do_reset(1'b1);
		cmd(1, 1, 0, 0, 19'h301, 4'hf, '0);
		for (int k = 1; k < 5; k++)
		begin
			if (k < 4)
				cmd(0, 0, 1, 0, '1, 4'hf, '0);
			else
				idle(1);
			`CHK(rdat, 32'ha0 + 32'(((1 ^ (k - 1)) + 3) % 4))
		end
	endtask
	task automatic t_stall;
		cmd(1, 1, 0, 0, 19'h100, 4'hf, '0);
		idle(1);
		`CHK(oe, 1'b1)
		`CHK(poe, 1'b1)
		oe_n = 1'b1;
		gate_n = 1'b1;
		#1;
		`CHK(oe, 1'b0)
		`CHK(poe, 1'b0)
		@(posedge clk);
		#1;
		oe_n = 1'b0;
		cmd(1, 1, 0, 0, 19'h200, 4'hf, '0);
		cmd(1, 1, 0, 0, 19'h200, 4'hf, '0);
		`CHK({rpar, rdat}, 36'h9_deadbeef)
		`CHK(oe, 1'b1)
		gate_n = 1'b0;
		idle(1);
		`CHK(oe, 1'b0)
	endtask
	task automatic t_sleep;
		zz = 1'b1;
		idle(1);
		`CHK(asleep, 1'b0)
		idle(1);
		`CHK(asleep, 1'b1)
		idle(1);
		`CHK(asleep, 1'b1)
		zz = 1'b0;
		idle(1);
		`CHK(asleep, 1'b0)
		idle(1);
		`CHK(asleep, 1'b0)
		idle(1);
		rd_chk(19'h100, 36'h9_deadbeef);
	endtask
	initial
	begin
		do_reset(1'b0);
		t_write_read;
		t_lanes;
		t_burst;
		t_stall;
		t_sleep;
		report_and_stop;
	end
endmodule // pipelined_burst_sram_core_tb
bind pipelined_burst_sram_core sram_core_monitor MON (.CLK_IN, .RESET_N_IN, .CLOCK_GATE_N_IN,
	.CHIP_SELECT_1_N_IN, .CHIP_SELECT_2_IN, .CHIP_SELECT_3_N_IN, .ADVANCE_OR_LOAD_IN,
	.WRITE_N_IN, .OUTPUT_ENABLE_N_IN, .SLEEP_REQUEST_IN, .DATA_OUT, .DATA_OE_OUT, .ASLEEP_OUT);
`default_nettype wire
